// ---- hdl/foccl_core.v ----
// field-oriented current loop with second-order suppression filter, apb slave
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "foccl_map.vh"

// What this block does
// (R1) clarke then park turn u and w currents plus angle into direct and quadrature
// (R2) two pi controllers run side by side on direct and quadrature error
// (R3) inverse park gives alpha and beta voltages; inverse clarke left to software
// (R4) quadrature current is held perpendicular to the rotor flux axis
// (R5) direct current sits on the flux axis, command normally zero
// (R6) one complete sample computed well inside a 16 kHz period
// (R7) host moves samples in and results out each period
// (R8) filter natural frequencies programmable 2 to 8000 Hz
// (R9) filter damping factors programmable 0 to 1000
// (R10) response is numerator over denominator second-order term
// (R11) filter on/off; off passes voltages unshaped
// (R12) input gain 0 to 1 in series with filter, reset to one
// (R13) filter acts on voltage commands; raw values stay readable
// (R14) voltages use raw scale plus or minus 1563
// (R15) v phase current derived from u and w by the core, as -iu - iw in the clarke step
// (R16) voltage limit clamps pi integrator and pi output
// (R17) biquad updated once per sample from frequency and damping
// (R18) done flag marks valid outputs; inputs latched at start
// (R19) integrators persist and update once per completed sample
module foccl_core #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
)(
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire result_valid,
  input wire result_ready,
  output wire [31:0] result_data
);
  localparam ST_IDLE = 3'h0;
  localparam ST_CLARKE = 3'h1;
  localparam ST_PARK = 3'h2;
  localparam ST_PI = 3'h3;
  localparam ST_IPARK = 3'h4;
  localparam ST_FILT = 3'h5;
  localparam ST_PUSH = 3'h6;

  // =========================================================
  // registers
  reg filt_en;
  reg [15:0] phase_u_current;
  reg [15:0] phase_w_current;
  reg [15:0] angle;
  reg [15:0] direct_cmd;
  reg [15:0] quad_cmd;
  reg [15:0] kp;
  reg [15:0] ki;
  reg [15:0] vlimit;
  reg [15:0] numerator_natural_freq;
  reg [15:0] denominator_natural_freq;
  reg [19:0] numerator_damping;
  reg [19:0] denominator_damping;
  reg [15:0] in_gain;
  reg busy;
  reg done;
  reg [2:0] state;
  // snapshot of phase currents and angle so mid-sample writes to them cannot disturb the math
  reg signed [15:0] s_iu;
  reg signed [15:0] s_iw;
  reg signed [15:0] s_sin;
  reg signed [15:0] s_cos;
  reg signed [17:0] i_alpha;
  reg signed [17:0] i_beta;
  reg signed [15:0] direct_current;
  reg signed [15:0] quadrature_current;
  reg signed [15:0] int_d;
  reg signed [15:0] int_q;
  reg signed [15:0] raw_vd;
  reg signed [15:0] raw_vq;
  reg signed [15:0] direct_voltage_cmd;
  reg signed [15:0] quadrature_voltage_cmd;
  reg signed [15:0] v_alpha;
  reg signed [15:0] v_beta;
  // biquad history, index 0 direct, 1 quadrature
  reg signed [15:0] x1 [0:1];
  reg signed [15:0] x2 [0:1];
  reg signed [15:0] y1 [0:1];
  reg signed [15:0] y2 [0:1];

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire fifo_ready;
  wire start_req = wr_en && (paddr == `FOCCL_CTRL) && pwdata[`FOCCL_CTRL_START];
  // settings clamp on write so software reads back what the filter uses
  wire [15:0] wr_freq = (pwdata[15:0] < `FOCCL_FREQ_MIN) ? `FOCCL_FREQ_MIN :
    (pwdata[15:0] > `FOCCL_FREQ_MAX) ? `FOCCL_FREQ_MAX : pwdata[15:0]; // (R8)
  wire [19:0] wr_zeta = (pwdata[19:0] > `FOCCL_ZETA_MAX) ? `FOCCL_ZETA_MAX : pwdata[19:0]; // (R9)
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // =========================================================
  // helpers
  function signed [15:0] sat16;
    input signed [35:0] v;
    input [15:0] lim;
    begin
      if (v > $signed({20'h00000, lim}))
        sat16 = lim;
      else if (v < -$signed({20'h00000, lim}))
        sat16 = -lim;
      else
        sat16 = v[15:0];
    end
  endfunction

  // sine of angle 0..65535 per turn, fixed point q14, parabolic approximation
  function signed [15:0] sine_q14;
    input [15:0] a;
    reg signed [17:0] x;
    reg signed [35:0] p;
    begin
      x = {2'b00, a[14:0]} - 18'sh04000;
      p = 36'sh10000000 - x * x;
      sine_q14 = a[15] ? -$signed(p[29:14]) : $signed(p[29:14]);
    end
  endfunction

  // =========================================================
  // coefficient derivation, once per sample from the settings (R17)
  // w = 2*pi*f/fs in q14; a simplified matched form keeps it cheap
  wire [15:0] fn_c = (numerator_natural_freq < `FOCCL_FREQ_MIN) ? `FOCCL_FREQ_MIN :
    (numerator_natural_freq > `FOCCL_FREQ_MAX) ? `FOCCL_FREQ_MAX : numerator_natural_freq; // (R8)
  wire [15:0] fd_c = (denominator_natural_freq < `FOCCL_FREQ_MIN) ? `FOCCL_FREQ_MIN :
    (denominator_natural_freq > `FOCCL_FREQ_MAX) ? `FOCCL_FREQ_MAX : denominator_natural_freq; // (R8)
  wire [19:0] zn_c = (numerator_damping > `FOCCL_ZETA_MAX) ? `FOCCL_ZETA_MAX : numerator_damping; // (R9)
  wire [19:0] zd_c = (denominator_damping > `FOCCL_ZETA_MAX) ? `FOCCL_ZETA_MAX : denominator_damping; // (R9)
  // 2*pi/16000 in q24 is about 6588
  wire [31:0] wn = (fn_c * 32'h000019BC) >> 10;
  wire [31:0] wd = (fd_c * 32'h000019BC) >> 10;
  wire [15:0] wn_q = (wn > 32'h00007FFF) ? 16'h7FFF : wn[15:0];
  wire [15:0] wd_q = (wd > 32'h00007FFF) ? 16'h7FFF : wd[15:0];
  // damping in q10, term 2*z*w in q14
  wire [35:0] zwn = (zn_c * wn_q) >> 9;
  wire [35:0] zwd = (zd_c * wd_q) >> 9;
  wire [31:0] wwn = (wn_q * wn_q) >> 14;
  wire [31:0] wwd = (wd_q * wd_q) >> 14;
  // numerator b: 1 + 2zw + w^2, -(2 + 2zw), 1 ; denominator likewise, normalised by den a0
  wire signed [23:0] b1 = -$signed({6'h00, zwn[17:0]}) - 24'sh008000;
  wire signed [23:0] b0 = 24'sh004000 + $signed({6'h00, zwn[17:0]}) + $signed({8'h00, wwn[15:0]});
  wire signed [23:0] a1 = -$signed({6'h00, zwd[17:0]}) - 24'sh008000;
  wire signed [23:0] a0 = 24'sh004000 + $signed({6'h00, zwd[17:0]}) + $signed({8'h00, wwd[15:0]});

  // biquad step per axis, shared direct form one (R10)
  function signed [15:0] biquad;
    input signed [15:0] x;
    input signed [15:0] xa;
    input signed [15:0] xb;
    input signed [15:0] ya;
    input signed [15:0] yb;
    input signed [23:0] nb0;
    input signed [23:0] nb1;
    input signed [23:0] da0;
    input signed [23:0] da1;
    reg signed [47:0] acc;
    reg signed [47:0] q;
    begin
      acc = nb0 * x + nb1 * xa + 24'sh004000 * xb - da1 * ya - 24'sh004000 * yb;
      q = acc / da0;
      biquad = sat16(q[35:0], 16'h7FFF);
    end
  endfunction

  // =========================================================
  // register writes
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      filt_en <= 1'b0;
      phase_u_current <= 16'h0000;
      phase_w_current <= 16'h0000;
      angle <= 16'h0000;
      direct_cmd <= 16'h0000; // (R5)
      quad_cmd <= 16'h0000;
      kp <= 16'h0000;
      ki <= 16'h0000;
      vlimit <= `FOCCL_VLIMIT_RST; // (R14)
      numerator_natural_freq <= `FOCCL_FN_RST;
      denominator_natural_freq <= `FOCCL_FN_RST;
      numerator_damping <= `FOCCL_Z_RST;
      denominator_damping <= `FOCCL_Z_RST;
      in_gain <= `FOCCL_GAIN_ONE; // (R12)
    end
    else if (wr_en)
    begin
      case (paddr)
        `FOCCL_CTRL: filt_en <= pwdata[`FOCCL_CTRL_FILT_EN]; // (R11)
        `FOCCL_PHASE_U: phase_u_current <= pwdata[15:0];
        `FOCCL_PHASE_W: phase_w_current <= pwdata[15:0];
        `FOCCL_ANGLE: angle <= pwdata[15:0];
        `FOCCL_ID_CMD: direct_cmd <= pwdata[15:0];
        `FOCCL_IQ_CMD: quad_cmd <= pwdata[15:0];
        `FOCCL_KP: kp <= pwdata[15:0];
        `FOCCL_KI: ki <= pwdata[15:0];
        `FOCCL_VLIMIT: vlimit <= (pwdata[15:0] > `FOCCL_VLIMIT_RST) ? `FOCCL_VLIMIT_RST : pwdata[15:0]; // (R14)
        `FOCCL_FILT_FN: numerator_natural_freq <= wr_freq; // (R8)
        `FOCCL_FILT_FD: denominator_natural_freq <= wr_freq; // (R8)
        `FOCCL_FILT_ZN: numerator_damping <= wr_zeta; // (R9)
        `FOCCL_FILT_ZD: denominator_damping <= wr_zeta; // (R9)
        `FOCCL_FILT_GAIN: in_gain <= (pwdata[15:0] > `FOCCL_GAIN_ONE) ? `FOCCL_GAIN_ONE : pwdata[15:0]; // (R12)
        default: ;
      endcase
    end
  end

  // =========================================================
  // sequencer, one stage per clock, about seven cycles per sample (R6)
  wire signed [31:0] e_d = $signed(direct_cmd) - direct_current;
  wire signed [31:0] e_q = $signed(quad_cmd) - quadrature_current;
  // product kept at 32 bits so the 1/sqrt3 scaling cannot wrap
  wire signed [31:0] beta_prod = (-$signed(s_iu) - ($signed(s_iw) <<< 1)) * 32'sh0000024F;
  wire signed [15:0] nid = sat16(int_d + ((e_d * $signed(ki)) >>> 10), vlimit); // (R16)
  wire signed [15:0] niq = sat16(int_q + ((e_q * $signed(ki)) >>> 10), vlimit); // (R16)
  wire signed [15:0] gd = sat16((direct_voltage_cmd * $signed({1'b0, in_gain})) >>> 10, 16'h7FFF);
  wire signed [15:0] gq = sat16((quadrature_voltage_cmd * $signed({1'b0, in_gain})) >>> 10, 16'h7FFF);
  wire signed [15:0] fd_out = biquad(gd, x1[0], x2[0], y1[0], y2[0], b0, b1, a0, a1);
  wire signed [15:0] fq_out = biquad(gq, x1[1], x2[1], y1[1], y2[1], b0, b1, a0, a1);
  integer k;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      s_iu <= 16'h0000;
      s_iw <= 16'h0000;
      s_sin <= 16'h0000;
      s_cos <= 16'h0000;
      i_alpha <= 18'h00000;
      i_beta <= 18'h00000;
      direct_current <= 16'h0000;
      quadrature_current <= 16'h0000;
      int_d <= 16'h0000;
      int_q <= 16'h0000;
      raw_vd <= 16'h0000;
      raw_vq <= 16'h0000;
      direct_voltage_cmd <= 16'h0000;
      quadrature_voltage_cmd <= 16'h0000;
      v_alpha <= 16'h0000;
      v_beta <= 16'h0000;
      for (k = 0; k < 2; k = k + 1)
      begin
        x1[k] <= 16'h0000;
        x2[k] <= 16'h0000;
        y1[k] <= 16'h0000;
        y2[k] <= 16'h0000;
      end
    end
    else
    begin
      // clearing done while a new sample finishes: completion wins
      if (wr_en && paddr == `FOCCL_CTRL && pwdata[`FOCCL_CTRL_CLR_INT] && state != ST_PUSH)
      begin
        done <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          if (start_req)
          begin
            s_iu <= phase_u_current; // (R18)
            s_iw <= phase_w_current; // (R18)
            s_sin <= sine_q14(angle);
            s_cos <= sine_q14(angle + 16'h4000);
            busy <= 1'b1;
            done <= 1'b0;
            state <= ST_CLARKE;
          end
        end
        ST_CLARKE:
        begin
          // alpha = iu, beta = (iu + 2 iv)/sqrt3 with iv = -iu - iw (R1)
          i_alpha <= {{2{s_iu[15]}}, s_iu};
          i_beta <= beta_prod[27:10]; // (R1)
          state <= ST_PARK;
        end
        ST_PARK:
        begin
          // d on flux axis, q 90 degrees ahead (R4) (R5) (R1)
          direct_current <= sat16((i_alpha * s_cos + i_beta * s_sin) >>> 14, 16'h7FFF);
          quadrature_current <= sat16((i_beta * s_cos - i_alpha * s_sin) >>> 14, 16'h7FFF);
          state <= ST_PI;
        end
        ST_PI:
        begin
          int_d <= nid; // (R19) (R16)
          int_q <= niq; // (R19) (R16)
          raw_vd <= sat16(nid + ((e_d * $signed(kp)) >>> 10), vlimit); // (R2) (R16)
          raw_vq <= sat16(niq + ((e_q * $signed(kp)) >>> 10), vlimit); // (R2) (R16)
          state <= ST_FILT;
        end
        ST_FILT:
        begin
          direct_voltage_cmd <= raw_vd;
          quadrature_voltage_cmd <= raw_vq;
          state <= ST_IPARK;
        end
        ST_IPARK:
        begin
          if (filt_en)
          begin
            direct_voltage_cmd <= sat16(fd_out, vlimit); // (R13) (R17)
            quadrature_voltage_cmd <= sat16(fq_out, vlimit); // (R13) (R17)
            x1[0] <= gd;
            x2[0] <= x1[0];
            y1[0] <= fd_out;
            y2[0] <= y1[0];
            x1[1] <= gq;
            x2[1] <= x1[1];
            y1[1] <= fq_out;
            y2[1] <= y1[1];
          end
          else
          begin
            direct_voltage_cmd <= gd; // (R11) (R12)
            quadrature_voltage_cmd <= gq; // (R11) (R12)
          end
          state <= ST_PUSH;
        end
        ST_PUSH:
        begin
          // inverse park of final commands (R3)
          v_alpha <= sat16((direct_voltage_cmd * s_cos - quadrature_voltage_cmd * s_sin) >>> 14, 16'h7FFF);
          v_beta <= sat16((direct_voltage_cmd * s_sin + quadrature_voltage_cmd * s_cos) >>> 14, 16'h7FFF);
          if (fifo_ready)
          begin
            busy <= 1'b0;
            done <= 1'b1; // (R18)
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // result stream: packed direct and quadrature commands per sample
  foccl_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(state == ST_PUSH),
    .in_ready(fifo_ready),
    .in_data({quadrature_voltage_cmd, direct_voltage_cmd}),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data)
  );

  // =========================================================
  // read mux
  always @*
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      case (paddr)
        `FOCCL_CTRL: prdata = {30'h00000000, filt_en, 1'b0};
        `FOCCL_STATUS: prdata = {30'h00000000, done, busy};
        `FOCCL_PHASE_U: prdata = {16'h0000, phase_u_current};
        `FOCCL_PHASE_W: prdata = {16'h0000, phase_w_current};
        `FOCCL_ANGLE: prdata = {16'h0000, angle};
        `FOCCL_ID_CMD: prdata = {16'h0000, direct_cmd};
        `FOCCL_IQ_CMD: prdata = {16'h0000, quad_cmd};
        `FOCCL_KP: prdata = {16'h0000, kp};
        `FOCCL_KI: prdata = {16'h0000, ki};
        `FOCCL_VLIMIT: prdata = {16'h0000, vlimit};
        `FOCCL_FILT_FN: prdata = {16'h0000, numerator_natural_freq};
        `FOCCL_FILT_FD: prdata = {16'h0000, denominator_natural_freq};
        `FOCCL_FILT_ZN: prdata = {12'h000, numerator_damping};
        `FOCCL_FILT_ZD: prdata = {12'h000, denominator_damping};
        `FOCCL_FILT_GAIN: prdata = {16'h0000, in_gain};
        `FOCCL_VD_OUT: prdata = {{16{direct_voltage_cmd[15]}}, direct_voltage_cmd};
        `FOCCL_VQ_OUT: prdata = {{16{quadrature_voltage_cmd[15]}}, quadrature_voltage_cmd};
        `FOCCL_VD_RAW: prdata = {{16{raw_vd[15]}}, raw_vd}; // (R13)
        `FOCCL_VQ_RAW: prdata = {{16{raw_vq[15]}}, raw_vq}; // (R13)
        `FOCCL_ALPHA_OUT: prdata = {{16{v_alpha[15]}}, v_alpha};
        `FOCCL_BETA_OUT: prdata = {{16{v_beta[15]}}, v_beta};
        `FOCCL_ID_OUT: prdata = {{16{direct_current[15]}}, direct_current};
        `FOCCL_IQ_OUT: prdata = {{16{quadrature_current[15]}}, quadrature_current};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule // foccl_core

// ---- hdl/foccl_fifo.v ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module foccl_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
)(
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // foccl_fifo

// ---- hdl/foccl_map.vh ----
// register offsets, field positions, reset values and timing counts for the current loop block
`ifndef FOCCL_MAP_VH
`define FOCCL_MAP_VH

// =========================================================
// register byte offsets
`define FOCCL_CTRL 12'h000
`define FOCCL_STATUS 12'h004
`define FOCCL_PHASE_U 12'h008
`define FOCCL_PHASE_W 12'h00C
`define FOCCL_ANGLE 12'h010
`define FOCCL_ID_CMD 12'h014
`define FOCCL_IQ_CMD 12'h018
`define FOCCL_KP 12'h01C
`define FOCCL_KI 12'h020
`define FOCCL_VLIMIT 12'h024
`define FOCCL_FILT_FN 12'h028
`define FOCCL_FILT_FD 12'h02C
`define FOCCL_FILT_ZN 12'h030
`define FOCCL_FILT_ZD 12'h034
`define FOCCL_FILT_GAIN 12'h038
`define FOCCL_VD_OUT 12'h03C
`define FOCCL_VQ_OUT 12'h040
`define FOCCL_VD_RAW 12'h044
`define FOCCL_VQ_RAW 12'h048
`define FOCCL_ALPHA_OUT 12'h04C
`define FOCCL_BETA_OUT 12'h050
`define FOCCL_ID_OUT 12'h054
`define FOCCL_IQ_OUT 12'h058

// =========================================================
// fields
`define FOCCL_CTRL_START 0
`define FOCCL_CTRL_FILT_EN 1
`define FOCCL_CTRL_CLR_INT 2
`define FOCCL_STAT_BUSY 0
`define FOCCL_STAT_DONE 1

// =========================================================
// reset values and ranges
`define FOCCL_VLIMIT_RST 16'h061B
`define FOCCL_GAIN_ONE 16'h0400
`define FOCCL_FREQ_MIN 16'h0002
`define FOCCL_FREQ_MAX 16'h1F40
`define FOCCL_ZETA_MAX 20'hFA000
`define FOCCL_FN_RST 16'h03E8
`define FOCCL_Z_RST 20'h00400

// =========================================================
// timing
`define FOCCL_CLK_HZ 125000000
`define FOCCL_SAMPLE_HZ 16000
`define FOCCL_SAMPLE_CYC (`FOCCL_CLK_HZ / `FOCCL_SAMPLE_HZ)

`endif

// ---- tb/foccl_checker.sv ----
// port checker for the current loop block
`timescale 1ns/100ps
`include "foccl_map.vh"
module foccl_checker (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire result_valid,
  input wire result_ready,
  input wire [31:0] result_data
);
  // ==========================================
  // cycles since the last start request
  reg [7:0] since;
  wire rd = psel && penable && !pwrite;
  wire go = psel && penable && pwrite && paddr == `FOCCL_CTRL && pwdata[0];
  wire vd_ok = result_data[15:0] <= 16'h61B || result_data[15:0] >= 16'hF9E5;
  wire vq_ok = result_data[31:16] <= 16'h61B || result_data[31:16] >= 16'hF9E5;
  always @(posedge clk)
  begin
    if (!rstn || go)
      since <= 8'h0;
    else if (since != 8'hFF)
      since <= since + 8'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // assertions
  a_done_latency: assert property ($rose(result_valid) |-> since <= 8'h8)
    else $error("result came too late after start");
  a_result_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("result word changed while stalled");
  a_vlim_read: assert property (rd && paddr == `FOCCL_VLIMIT |-> prdata <= 32'h61B)
    else $error("voltage limit above range");
  a_gain_read: assert property (rd && paddr == `FOCCL_FILT_GAIN |-> prdata <= 32'h400)
    else $error("gain above one");
  a_freq_read: assert property (rd && (paddr == `FOCCL_FILT_FN || paddr == `FOCCL_FILT_FD)
    |-> prdata >= 32'h2 && prdata <= 32'h1F40)
    else $error("frequency out of range");
  a_damp_read: assert property (rd && (paddr == `FOCCL_FILT_ZN || paddr == `FOCCL_FILT_ZD)
    |-> prdata <= 32'hFA000)
    else $error("damping out of range");
  a_raw_scale: assert property (rd && (paddr == `FOCCL_VD_RAW || paddr == `FOCCL_VQ_RAW)
    |-> prdata[15:0] <= 16'h61B || prdata[15:0] >= 16'hF9E5)
    else $error("raw voltage out of scale");
  a_word_scale: assert property (result_valid |-> vd_ok && vq_ok)
    else $error("result word out of scale");
endmodule // foccl_checker

// ---- tb/foccl_core_tb.sv ----
// self-checking bench for the current loop block
`timescale 1ns/100ps
`include "foccl_map.vh"
module foccl_core_tb;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0;
  reg stall = 1'b0;
  reg fen = 1'b0;
  reg [31:0] d;
  reg [15:0] c0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire result_valid;
  wire result_ready;
  wire [31:0] result_data;
  wire [15:0] cnt;
  wire [31:0] last;
  integer fail_count = 0;
  integer n_checks = 0;
  integer i;

  always #4 clk = ~clk;

  foccl_core dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data));
  foccl_host host_u (.clk(clk), .rstn(rstn), .stall(stall), .result_valid(result_valid),
    .result_ready(result_ready), .result_data(result_data), .count(cnt), .last(last));

  // ==========================================
  // bus and compare tasks
  task xf(input w, input [11:0] a, input [31:0] v);
  begin
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task ck(input [31:0] g, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task near(input [15:0] g, input [15:0] e, input integer t);
    integer dv;
  begin
    dv = $signed(g) - $signed(e);
    n_checks = n_checks + 1;
    if ((^g === 1'bx) || dv > t || dv < -t)
    begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task rc(input [11:0] a, input [31:0] e);
  begin
    xf(1'b0, a, 32'h0);
    ck(d, e);
  end
  endtask
  task rn(input [11:0] a, input [15:0] e, input integer t);
  begin
    xf(1'b0, a, 32'h0);
    near(d[15:0], e, t);
  end
  endtask
  task wc(input [11:0] a, input [31:0] w, input [31:0] e);
  begin
    xf(1'b1, a, w);
    rc(a, e);
  end
  endtask
  task start;
  begin
    xf(1'b1, `FOCCL_CTRL, {30'h0, fen, 1'b1});
  end
  endtask
  // polls status, a missing done counts as a mismatch
  task wait_done;
    integer k;
  begin
    d = 32'h0;
    for (k = 0; k < 60 && d[1] !== 1'b1; k = k + 1)
      xf(1'b0, `FOCCL_STATUS, 32'h0);
    ck({31'h0, d[1]}, 32'h1);
  end
  endtask
  task close_out;
  begin
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // ==========================================
  // tests
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rc(`FOCCL_VLIMIT, 32'h61B);
    rc(`FOCCL_FILT_GAIN, 32'h400);
    rc(`FOCCL_FILT_FN, 32'h3E8);
    rc(`FOCCL_FILT_ZD, 32'h400);
    rc(`FOCCL_STATUS, 32'h0);
    rc(12'hFFC, 32'h0);
    $display("test reset values done");
    wc(`FOCCL_FILT_FN, 32'h1, 32'h2);
    wc(`FOCCL_FILT_FD, 32'h2328, 32'h1F40);
    wc(`FOCCL_FILT_ZN, 32'hFFFFF, 32'hFA000);
    wc(`FOCCL_FILT_ZD, 32'h0, 32'h0);
    wc(`FOCCL_VLIMIT, 32'h7D0, 32'h61B);
    wc(`FOCCL_FILT_GAIN, 32'h800, 32'h400);
    $display("test setting ranges done");
    wc(`FOCCL_VLIMIT, 32'h64, 32'h64);
    xf(1'b1, `FOCCL_KP, 32'h4000);
    xf(1'b1, `FOCCL_KI, 32'h0);
    xf(1'b1, `FOCCL_ID_CMD, 32'h0);
    xf(1'b1, `FOCCL_IQ_CMD, 32'h0);
    xf(1'b1, `FOCCL_PHASE_U, 32'h3E8);
    xf(1'b1, `FOCCL_PHASE_W, 32'hFFFFFE0C);
    xf(1'b1, `FOCCL_ANGLE, 32'h0);
    start;
    wait_done;
    rn(`FOCCL_ID_OUT, 16'h3E8, 4);
    rn(`FOCCL_IQ_OUT, 16'h0, 4);
    rn(`FOCCL_VD_RAW, 16'hFF9C, 0);
    rn(`FOCCL_VD_OUT, 16'hFF9C, 0);
    near(last[15:0], 16'hFF9C, 0);
    xf(1'b1, `FOCCL_ANGLE, 32'h4000);
    start;
    wait_done;
    rn(`FOCCL_IQ_OUT, 16'hFC18, 4);
    rn(`FOCCL_ID_OUT, 16'h0, 4);
    rn(`FOCCL_VQ_RAW, 16'h64, 0);
    near(last[31:16], 16'h64, 0);
    $display("test transforms done");
    xf(1'b1, `FOCCL_ANGLE, 32'h0);
    xf(1'b1, `FOCCL_FILT_GAIN, 32'h200);
    start;
    wait_done;
    rn(`FOCCL_VD_RAW, 16'hFF9C, 0);
    rn(`FOCCL_VD_OUT, 16'hFFCE, 1);
    // equal numerator and denominator terms must cancel
    xf(1'b1, `FOCCL_FILT_GAIN, 32'h400);
    xf(1'b1, `FOCCL_FILT_FN, 32'h3E8);
    xf(1'b1, `FOCCL_FILT_FD, 32'h3E8);
    xf(1'b1, `FOCCL_FILT_ZN, 32'h400);
    xf(1'b1, `FOCCL_FILT_ZD, 32'h400);
    fen = 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      start;
      wait_done;
    end
    rn(`FOCCL_VD_OUT, 16'hFF9C, 3);
    fen = 1'b0;
    $display("test gain and filter done");
    c0 = cnt;
    start;
    start;
    wait_done;
    repeat (8) @(posedge clk);
    ck({16'h0, cnt - c0}, 32'h1);
    stall <= 1'b1;
    c0 = cnt;
    for (i = 0; i < 32; i = i + 1)
    begin
      start;
      wait_done;
    end
    start;
    repeat (20) @(posedge clk);
    rc(`FOCCL_STATUS, 32'h1);
    stall <= 1'b0;
    wait_done;
    repeat (40) @(posedge clk);
    ck({16'h0, cnt - c0}, 32'h21);
    $display("test busy and buffer done");
    close_out;
  end

  // hang guard, far beyond the fewer than one thousand cycles the tests need
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count = fail_count + 1;
    close_out;
  end
endmodule // foccl_core_tb

bind foccl_core foccl_checker chk_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .result_valid(result_valid), .result_ready(result_ready),
  .result_data(result_data));

// ---- tb/foccl_host.sv ----
// host model that collects result words from the block
`timescale 1ns/100ps
module foccl_host (
  input wire clk,
  input wire rstn,
  input wire stall,
  input wire result_valid,
  output reg result_ready,
  input wire [31:0] result_data,
  output reg [15:0] count,
  output reg [31:0] last
);
  // ==========================================
  // sink, stalls only when the bench asks
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      result_ready <= 1'b0;
      count <= 16'h0;
      last <= 32'h0;
    end
    else
    begin
      result_ready <= !stall;
      if (result_valid && result_ready)
      begin
        count <= count + 16'h1;
        last <= result_data;
      end
    end
  end
endmodule // foccl_host
